// File: logic/compact_timer_module.sv
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_regs.svh"
module compact_timer_module
  import compact_timer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        high_clk_tick,
  input  wire logic        sub_clk_tick,
  input  wire logic        ext_count_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_inverted_pin,
  output logic             match_a_flag,
  output logic             match_p_flag
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  bus_phase_e phase_q,  phase_d;   // bus answer phase
  byte_t      ctrl0_q,  ctrl0_d;   // pause, clock select, run, period
  byte_t      ctrl1_q,  ctrl1_d;   // mode, io, oc, pol, dpx, clear sel
  byte_t      buf_q,    buf_d;     // shared low byte buffer
  count_t     cnt_q,    cnt_d;     // main counter
  count_t     cmpa_q,   cmpa_d;    // compare a value
  logic [5:0] pre_s_q,  pre_s_d;   // system clock prescaler
  logic [5:0] pre_h_q,  pre_h_d;   // high clock prescaler
  logic       ext_q;               // previous external pin level
  logic       run_q;               // previous run enable
  logic       lvl_q,    lvl_d;     // output level before polarity
  logic       fa_q,     fa_d;      // compare a flag
  logic       fp_q,     fp_d;      // period flag
  logic [31:0] rd_q,    rd_d;      // read data register
  logic       pin_d;               // polarised pin value
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic       run, pause, tick, run_rise, wr_take, rd_take;
  logic       hit_a, hit_p, clr_hit, pwm_act;
  logic [2:0] csel, per;
  logic [1:0] mode, io;
  count_t     inc;
  assign run      = ctrl0_q[`C0_RUN];
  assign pause    = ctrl0_q[`C0_PAUSE];
  assign csel     = ctrl0_q[6:4];
  assign per      = ctrl0_q[2:0];
  assign mode     = ctrl1_q[7:6];
  assign io       = ctrl1_q[5:4];
  assign run_rise = run & ~run_q;
  assign wr_take  = write & (phase_q == bus_answer);
  assign rd_take  = read & (phase_q == bus_answer);
  assign inc      = cnt_q + `CNT_ONE;             // wraps at 1023
  // period compare on top bits; zero means overflow
  assign hit_p    = (per == `PER_ZERO) ? (inc == `CNT_RST)
                  : (inc[9:7] == per) && (inc[6:0] == `LOW7_ZERO);
  assign hit_a    = (inc == cmpa_q);
  assign clr_hit  = ctrl1_q[`C1_CCLR] ? hit_a : hit_p;
  // ----------------------------------------------------------------------
  // clock source selection and prescalers
  // ----------------------------------------------------------------------
  always_comb begin
    pre_s_d = (pre_s_q == `SYS4_LAST) ? `PRE_RST : pre_s_q + `PRE_ONE;
    pre_h_d = pre_h_q;
    if (high_clk_tick) begin
      pre_h_d = pre_h_q + `PRE_ONE;
    end
    case (csel)
      `SEL_SYS4:     tick = (pre_s_q == `SYS4_LAST);
      `SEL_SYS:      tick = 1'b1;
      `SEL_H16:      tick = high_clk_tick & (pre_h_q[3:0] == `H16_LAST);
      `SEL_H64:      tick = high_clk_tick & (pre_h_q == `H64_LAST);
      `SEL_SUB0,
      `SEL_SUB1:     tick = sub_clk_tick;
      `SEL_EXT_RISE: tick = ext_count_clock_pin & ~ext_q;
      `SEL_EXT_FALL: tick = ~ext_count_clock_pin & ext_q;
      default:       tick = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------------
  // counter, flags and output level
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    fa_d  = fa_q;
    fp_d  = fp_q;
    lvl_d = lvl_q;
    // software clears flags by writing ones
    if (wr_take && address == `FLAG_OFS) begin
      fa_d = fa_q & ~writedata[`FLAG_A];
      fp_d = fp_q & ~writedata[`FLAG_P];
    end
    // pwm: edge aligned, duty from compare a, or from the period bits when dpx is set
    if (ctrl1_q[`C1_DPX]) begin
      pwm_act = (cnt_q < {per, `LOW7_ZERO});
    end else begin
      pwm_act = (cnt_q < cmpa_q);
    end
    if (run_rise) begin
      cnt_d = `CNT_RST;
      lvl_d = ctrl1_q[`C1_OC];
    end else if (run && !pause && tick) begin
      cnt_d = clr_hit ? `CNT_RST : inc;
      if (hit_a) begin
        fa_d = 1'b1;                              // set beats clear
      end
      if (hit_p) begin
        fp_d = 1'b1;
      end
      if (mode == `MODE_CMP && hit_a) begin
        case (io)
          `IO_LOW:    lvl_d = 1'b0;
          `IO_HIGH:   lvl_d = 1'b1;
          `IO_TOGGLE: lvl_d = ~lvl_q;
          default:    lvl_d = lvl_q;
        endcase
      end
    end // else run low: residual count held
    if (mode == `MODE_PWM && run && !run_rise) begin
      case (io)
        `IO_PWM: lvl_d = pwm_act ? ctrl1_q[`C1_OC] : ~ctrl1_q[`C1_OC];
        `IO_LOW: lvl_d = ctrl1_q[`C1_OC];
        default: lvl_d = ~ctrl1_q[`C1_OC];
      endcase
    end
    // polarity applies outside timer mode
    pin_d = (mode != `MODE_TMR && ctrl1_q[`C1_POL]) ? ~lvl_d : lvl_d;
  end
  // ----------------------------------------------------------------------
  // bus slave and buffered byte pairs
  // ----------------------------------------------------------------------
  always_comb begin
    phase_d = (phase_q == bus_idle && (read || write)) ? bus_answer : bus_idle;
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    cmpa_d  = cmpa_q;
    buf_d   = buf_q;
    rd_d    = rd_q;
    if (phase_q == bus_idle && read) begin
      case (address)
        `CTRL0_OFS:   rd_d = {`RD_PAD, ctrl0_q};
        `CTRL1_OFS:   rd_d = {`RD_PAD, ctrl1_q};
        `CNT_LO_OFS,
        `CMPA_LO_OFS: rd_d = {`RD_PAD, buf_q};
        `CNT_HI_OFS:  rd_d = {`RD_PAD, 6'h00, cnt_q[9:8]};
        `CMPA_HI_OFS: rd_d = {`RD_PAD, 6'h00, cmpa_q[9:8]};
        `FLAG_OFS:    rd_d = {`RD_PAD, 6'h00, fp_q, fa_q};
        default:      rd_d = {`RD_PAD, `REG8_RST};
      endcase
    end
    if (rd_take && address == `CNT_HI_OFS) begin
      buf_d = cnt_q[7:0];
    end
    if (rd_take && address == `CMPA_HI_OFS) begin
      buf_d = cmpa_q[7:0];
    end
    if (wr_take) begin
      case (address)
        `CTRL0_OFS:   ctrl0_d = writedata[7:0];
        `CTRL1_OFS:   ctrl1_d = writedata[7:0];
        `CMPA_LO_OFS: buf_d   = writedata[7:0];
        `CMPA_HI_OFS: cmpa_d  = {writedata[1:0], buf_q};
        default:      buf_d   = buf_q;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q                   <= bus_idle;
      ctrl0_q                   <= `REG8_RST;
      ctrl1_q                   <= `REG8_RST;
      buf_q                     <= `REG8_RST;
      cnt_q                     <= `CNT_RST;
      cmpa_q                    <= `CNT_RST;
      pre_s_q                   <= `PRE_RST;
      pre_h_q                   <= `PRE_RST;
      ext_q                     <= 1'b0;
      run_q                     <= 1'b0;
      lvl_q                     <= 1'b0;
      fa_q                      <= 1'b0;
      fp_q                      <= 1'b0;
      rd_q                      <= 32'h00000000;
      waitrequest               <= 1'b1;
      timer_output_pin          <= 1'b0;
      timer_output_inverted_pin <= 1'b1;
    end else begin
      phase_q                   <= phase_d;
      ctrl0_q                   <= ctrl0_d;
      ctrl1_q                   <= ctrl1_d;
      buf_q                     <= buf_d;
      cnt_q                     <= cnt_d;
      cmpa_q                    <= cmpa_d;
      pre_s_q                   <= pre_s_d;
      pre_h_q                   <= pre_h_d;
      ext_q                     <= ext_count_clock_pin;
      run_q                     <= run;
      lvl_q                     <= lvl_d;
      fa_q                      <= fa_d;
      fp_q                      <= fp_d;
      rd_q                      <= rd_d;
      waitrequest               <= (phase_d != bus_answer);
      timer_output_pin          <= pin_d;
      timer_output_inverted_pin <= ~pin_d;
    end
  end
  assign readdata     = rd_q;
  assign match_a_flag = fa_q;
  assign match_p_flag = fp_q;
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  pin_inverse_a: assert property (
    timer_output_inverted_pin == ~timer_output_pin)
    else $error("inverted pin not complement");
  run_clear_a: assert property (
    run_rise |=> cnt_q == `CNT_RST)
    else $error("run rise did not clear counter");
  hold_off_a: assert property (
    !run && !run_rise |=> $stable(cnt_q))
    else $error("counter moved while off");
  count_step_a: assert property (
    run && !pause && tick && !run_rise && !clr_hit |=> cnt_q == $past(inc))
    else $error("counter did not step");
  clear_match_a: assert property (
    run && !pause && tick && !run_rise && clr_hit |=> cnt_q == `CNT_RST)
    else $error("match did not clear counter");
  flag_a_sticky_a: assert property (
    fa_q && !(wr_take && address == `FLAG_OFS) |=> fa_q)
    else $error("flag a dropped");
  flag_a_set_a: assert property (
    run && !pause && tick && !run_rise && hit_a |=> fa_q)
    else $error("flag a not set");
  flag_p_set_a: assert property (
    run && !pause && tick && !run_rise && hit_p |=> fp_q)
    else $error("flag p not set");
  hi_read_buf_a: assert property (
    rd_take && address == `CNT_HI_OFS |=> buf_q == $past(cnt_q[7:0]))
    else $error("high read did not capture low byte");
  hi_write_a: assert property (
    wr_take && address == `CMPA_HI_OFS |=> cmpa_q[7:0] == $past(buf_q))
    else $error("high write did not commit buffer");
  wait_answer_a: assert property (
    (read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("bus not answered");
  toggle_out_a: assert property (
    mode == `MODE_CMP && io == `IO_TOGGLE && run && !pause && tick
    && !run_rise && hit_a |=> lvl_q != $past(lvl_q))
    else $error("toggle missed");
  flag_p_sticky_a: assert property (
    fp_q && !(wr_take && address == `FLAG_OFS) |=> fp_q)
    else $error("flag p dropped");
  run_oc_a: assert property (
    run_rise |=> lvl_q == $past(ctrl1_q[`C1_OC]))
    else $error("run rise did not restore initial level");
  wrap_a: assert property (
    run && !pause && tick && !run_rise && (&cnt_q) |=> cnt_q == `CNT_RST)
    else $error("counter did not wrap to zero");
  // pin level follows duty compare, one edge late
  pwm_out_a: assert property (
    mode == `MODE_PWM && io == `IO_PWM && run && !run_rise && !ctrl1_q[`C1_DPX]
    && !ctrl1_q[`C1_POL]
    |=> timer_output_pin == ($past(cnt_q < cmpa_q) == $past(ctrl1_q[`C1_OC])))
    else $error("pwm level wrong");
  // main scenarios reached
  cov_clear_c: cover property (run && tick && clr_hit);
  cov_pwm_c:   cover property (mode == `MODE_PWM && $rose(timer_output_pin));
  cov_ext_c:   cover property (csel == `SEL_EXT_FALL && tick && run);
  cov_dpx_c:   cover property (mode == `MODE_PWM && ctrl1_q[`C1_DPX] && run);
  cov_wrap_c:  cover property (run && tick && (&cnt_q));
endmodule : compact_timer_module
`default_nettype wire

// File: logic/compact_timer_pkg.sv
package compact_timer_pkg;
  // bus answer phase
  typedef enum logic {
    bus_idle,
    bus_answer
  } bus_phase_e;
  typedef logic [9:0] count_t;  // counter and compare width
  typedef logic [7:0] byte_t;   // register width
endpackage : compact_timer_pkg

// File: logic/compact_timer_regs.svh
`ifndef COMPACT_TIMER_REGS_SVH
`define COMPACT_TIMER_REGS_SVH
// ----------------------------------------------------------------------
// register byte offsets on the avalon bus
// ----------------------------------------------------------------------
`define CTRL0_OFS     5'h00
`define CTRL1_OFS     5'h04
`define CNT_LO_OFS    5'h08
`define CNT_HI_OFS    5'h0c
`define CMPA_LO_OFS   5'h10
`define CMPA_HI_OFS   5'h14
`define FLAG_OFS      5'h18
// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define C0_PAUSE      7
`define C0_RUN        3
`define C1_OC         3
`define C1_POL        2
`define C1_DPX        1
`define C1_CCLR       0
`define FLAG_A        0
`define FLAG_P        1
`define MODE_CMP      2'h0
`define MODE_PWM      2'h2
`define MODE_TMR      2'h3
`define IO_LOW        2'h1
`define IO_HIGH       2'h2
`define IO_TOGGLE     2'h3
`define IO_PWM        2'h2
`define SEL_SYS4      3'h0
`define SEL_SYS       3'h1
`define SEL_H16       3'h2
`define SEL_H64       3'h3
`define SEL_SUB0      3'h4
`define SEL_SUB1      3'h5
`define SEL_EXT_RISE  3'h6
`define SEL_EXT_FALL  3'h7
// ----------------------------------------------------------------------
// reset values and prescaler terminal counts
// ----------------------------------------------------------------------
`define REG8_RST      8'h00
`define CNT_RST       10'h000
`define CNT_ONE       10'h001
`define PER_ZERO      3'h0
`define LOW7_ZERO     7'h00
`define PRE_RST       6'h00
`define PRE_ONE       6'h01
`define SYS4_LAST     6'h03
`define H16_LAST      4'hf
`define H64_LAST      6'h3f
`define RD_PAD        24'h000000
`endif

// File: tb/ext_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: event pin source, tick sources and output pin load
module ext_source_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic timer_output_pin,
  input  wire logic timer_output_inverted_pin,
  output logic      ext_count_clock_pin,
  output logic      high_clk_tick,
  output logic      sub_clk_tick,
  output logic      load_error
);
  logic [2:0] div_q;  // free running tick divider
  initial ext_count_clock_pin = 1'b0;
  // ticks: high clock every 4 cycles, subsystem every 8
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) div_q <= 3'h0;
    else div_q <= div_q + 3'h1;
  end
  assign high_clk_tick = (div_q[1:0] == 2'h3);
  assign sub_clk_tick  = (div_q == 3'h7);
  // load flags a pin pair that is not complementary
  assign load_error = !rst && (timer_output_pin === timer_output_inverted_pin);
  // n event pulses, 4 cycles high then 4 low, 5 low between pulses
  task automatic send(input int n);
    repeat (n) begin
      @(posedge sys_clk) ext_count_clock_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_count_clock_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : send
endmodule : ext_source_model
`default_nettype wire

// File: tb/test_compact_timer_module.sv
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_regs.svh"
module test_compact_timer_module
  import compact_timer_pkg::*;
;
  logic        sys_clk, rst, read, write, waitrequest;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic        hi_t, sub_t, ext_pin, pin, pin_n, fa, fp, load_error;
  logic [31:0] exp_q[$];  // expected read data, oldest first
  int          miscompares, n_tests, cycles, n;
  integer      seed;
  count_t      cmp;       // random compare value
  byte_t       io_tab [3] = '{8'h21, 8'h19, 8'h31};  // high, low, toggle
  // internal sources and their tick spacing in system clocks (high tick every 4)
  logic [2:0]  sel_tab [5] = '{`SEL_SYS4, `SEL_H16, `SEL_H64, `SEL_SUB0, `SEL_SUB1};
  int          per_tab [5] = '{4, 64, 256, 8, 8};
  compact_timer_module i_compact_timer_module (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .high_clk_tick(hi_t), .sub_clk_tick(sub_t), .ext_count_clock_pin(ext_pin),
    .timer_output_pin(pin), .timer_output_inverted_pin(pin_n),
    .match_a_flag(fa), .match_p_flag(fp));
  ext_source_model i_ext_source_model (
    .sys_clk(sys_clk), .rst(rst), .timer_output_pin(pin),
    .timer_output_inverted_pin(pin_n), .ext_count_clock_pin(ext_pin),
    .high_clk_tick(hi_t), .sub_clk_tick(sub_t), .load_error(load_error));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, expv);
    end
  endtask : check
  // one avalon transfer; for a read d is the expected byte
  task automatic bus(input logic wr, input logic [4:0] a, input byte_t d);
    @(posedge sys_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h000000, d};
    if (!wr) exp_q.push_back({24'h000000, d});
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // monitor: read answers against oldest note, pin pair, timeout
  always @(posedge sys_clk) begin
    if (read && waitrequest === 1'b0) check(readdata, exp_q.pop_front());
    if (load_error) check(1'b1, 1'b0);
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h00000000;
    seed = 75;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, unmapped place
    bus(0, `CTRL0_OFS, 8'h00);
    bus(0, `CTRL1_OFS, 8'h00);
    bus(0, `FLAG_OFS, 8'h00);
    bus(0, 5'h1c, 8'h00);
    $display("test reset finished");
    // buffered compare access, low alone does not commit
    cmp = {1'b1, 9'($random(seed))};
    bus(1, `CMPA_LO_OFS, cmp[7:0]);
    bus(0, `CMPA_HI_OFS, 8'h00);
    bus(0, `CMPA_LO_OFS, 8'h00);
    bus(1, `CMPA_LO_OFS, cmp[7:0]);
    bus(1, `CMPA_HI_OFS, {6'h00, cmp[9:8]});
    bus(0, `CMPA_HI_OFS, {6'h00, cmp[9:8]});
    bus(0, `CMPA_LO_OFS, cmp[7:0]);
    $display("test buffer finished");
    // event counting on both pin edges, hold while stopped
    for (int e = 0; e < 2; e++) begin
      bus(1, `CTRL0_OFS, 8'h00);
      bus(1, `CTRL1_OFS, 8'hc0);
      bus(1, `CTRL0_OFS, {1'b0, e ? `SEL_EXT_FALL : `SEL_EXT_RISE, 4'h8});
      i_ext_source_model.send(5);
      repeat (4) @(posedge sys_clk);
      bus(1, `CTRL0_OFS, {1'b0, e ? `SEL_EXT_FALL : `SEL_EXT_RISE, 4'h0});
      i_ext_source_model.send(3);
      bus(0, `CNT_HI_OFS, 8'h00);
      bus(0, `CNT_LO_OFS, 8'h05);
    end
    $display("test events finished");
    // period match at 128 clocks, sticky flag, clear
    bus(1, `CTRL0_OFS, 8'h00);
    bus(1, `CTRL1_OFS, 8'h00);
    bus(1, `FLAG_OFS, 8'h03);
    bus(1, `CTRL0_OFS, 8'h19);
    n = 0;
    while (fp !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check(n > 122 && n < 132, 1'b1);
    check(fa, 1'b0);
    bus(0, `FLAG_OFS, 8'h02);
    bus(1, `FLAG_OFS, 8'h02);
    bus(0, `FLAG_OFS, 8'h00);
    n = 0;
    while (fp !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check(n > 108 && n < 130, 1'b1);
    $display("test period finished");
    // internal clock sources: third tick reaches compare A of 3
    for (int s = 0; s < 5; s++) begin
      bus(1, `CTRL0_OFS, 8'h00);
      bus(1, `CTRL1_OFS, 8'h01);
      bus(1, `CMPA_LO_OFS, 8'h03);
      bus(1, `CMPA_HI_OFS, 8'h00);
      bus(1, `FLAG_OFS, 8'h03);
      bus(1, `CTRL0_OFS, {1'b0, sel_tab[s], 4'h8});
      n = 0;
      while (fa !== 1'b1 && n < 1000) begin
        @(posedge sys_clk);
        n++;
      end
      check(n > 2 * per_tab[s] && n < 3 * per_tab[s] + 4, 1'b1);
    end
    $display("test clock finished");
    // period zero: overflow after 1024 clocks, counter wraps to zero
    bus(1, `CTRL0_OFS, 8'h00);
    bus(1, `CTRL1_OFS, 8'h00);
    bus(1, `FLAG_OFS, 8'h03);
    bus(1, `CTRL0_OFS, 8'h18);
    n = 0;
    while (fp !== 1'b1 && n < 1100) begin
      @(posedge sys_clk);
      n++;
    end
    check(n > 1020 && n < 1030, 1'b1);
    bus(0, `CNT_HI_OFS, 8'h00);
    $display("test wrap finished");
    // compare output: high, low, toggle on compare A at 40
    for (int m = 0; m < 3; m++) begin
      bus(1, `CTRL0_OFS, 8'h00);
      bus(1, `CTRL1_OFS, io_tab[m]);
      bus(1, `CMPA_LO_OFS, 8'h28);
      bus(1, `CMPA_HI_OFS, 8'h00);
      bus(1, `FLAG_OFS, 8'h03);
      bus(1, `CTRL0_OFS, 8'h18);
      repeat (2) @(posedge sys_clk);
      check(pin, io_tab[m][3]);
      n = 0;
      while (pin === io_tab[m][3] && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      check(n > 32 && n < 44, 1'b1);
      check(fa, 1'b1);
    end
    $display("test compare finished");
    // edge pwm: duty 32 of 128, then duty 128 of 512 with inverted pin
    for (int p = 0; p < 2; p++) begin
      bus(1, `CTRL0_OFS, 8'h00);
      bus(1, `CTRL1_OFS, p ? 8'haf : 8'ha8);
      bus(1, `CMPA_LO_OFS, p ? 8'h00 : 8'h20);
      bus(1, `CMPA_HI_OFS, p ? 8'h02 : 8'h00);
      bus(1, `CTRL0_OFS, 8'h19);
      repeat (8) @(posedge sys_clk);
      n = 0;
      repeat (p ? 512 : 256) begin
        @(posedge sys_clk);
        if (pin === 1'b1) n++;
      end
      check(n, p ? 384 : 64);
    end
    $display("test pwm finished");
    final_report();
  end
endmodule : test_compact_timer_module
`default_nettype wire
